// file: src/irqf_defines.vh
`ifndef IRQF_DEFINES_VH
`define IRQF_DEFINES_VH

// ************************************************************
// register word indices (byte address divided by four)
// ************************************************************
`define IRQF_IDX_MASK2 8'h2b
`define IRQF_IDX_FILT 8'h2c
`define IRQF_IDX_PWR 8'h2d
`define IRQF_IDX_SRST 8'h30
`define IRQF_IDX_EVST 8'h31
`define IRQF_IDX_EVMSK 8'h32
`define IRQF_ADDR_W 10

// ************************************************************
// reset values
// ************************************************************
`define IRQF_RST_MASK2 8'h00
`define IRQF_RST_FILT 8'h23
`define IRQF_RST_PWR 2'h0
`define IRQF_RST_EVMSK 7'h00

// ************************************************************
// field positions
// ************************************************************
`define IRQF_POL_BIT 7
`define IRQF_SRC_HI 6
`define IRQF_RANGE_HI 7
`define IRQF_RANGE_LO 6
`define IRQF_FAST_BIT 5
`define IRQF_RSVD_BIT 4
`define IRQF_EXT_BIT 3
`define IRQF_RATE_HI 2
`define IRQF_RATE_LO 0
`define IRQF_NSRC 7

// ************************************************************
// codes and timing
// ************************************************************
`define IRQF_MODE_STANDBY 2'h0
`define IRQF_MODE_OPERATING_MODE_FIELD 2'h2
`define IRQF_RATE_MAX 3'h5
`define IRQF_SRST_KEY 8'h52
`define IRQF_MCLK_HZ 20000000
`define IRQF_SLOW_RATE_X2 25

`endif

// file: src/irqf_pin2_cfg.v
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "irqf_defines.vh"

module irqf_pin2_cfg #(
  parameter SLOW_PERIOD = `IRQF_MCLK_HZ * 2 / `IRQF_SLOW_RATE_X2
) (
  // clock and reset
  input wire mclk,
  input wire rst,
  // apb slave
  input wire [`IRQF_ADDR_W-1:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // status sources, levels
  input wire [`IRQF_NSRC-1:0] event_src,
  // second interrupt pin
  input wire second_irq_pin_in,
  output reg second_irq_pin_out,
  output reg second_irq_pin_oe,
  // configuration outputs
  output reg [1:0] full_scale_range,
  output reg fast_bus_mode_enable,
  output reg [2:0] output_sample_rate,
  output reg [2:0] filter_bw_code,
  output reg [1:0] operating_mode_field,
  output reg sample_strobe,
  // interrupt
  output reg irq
);

  // ************************************************************
  // functions
  // ************************************************************
  function [7:0] word_index;
    input [`IRQF_ADDR_W-1:0] a;
    begin
      word_index = a[`IRQF_ADDR_W-1:2];
    end
  endfunction

  function [31:0] rate_period;
    input [2:0] code;
    reg [2:0] c;
    begin
      c = (code > `IRQF_RATE_MAX) ? `IRQF_RATE_MAX : code;
      rate_period = SLOW_PERIOD >> c;
    end
  endfunction

  // ************************************************************
  // state
  // ************************************************************
  localparam [7:0] FILT_RST = `IRQF_RST_FILT;

  reg [7:0] irq_pin2_event_mask;
  reg [1:0] range_field;
  reg fast_bit;
  reg ext_trig;
  reg [2:0] rate_field;
  reg [1:0] mode_field;
  reg [`IRQF_NSRC-1:0] ev_status;
  reg [`IRQF_NSRC-1:0] ev_mask;
  reg [`IRQF_NSRC-1:0] src_prev;
  reg trig_prev;
  reg [31:0] tick_cnt;
  reg [31:0] rdata_mux;
  reg hit;

  wire access = psel & penable & pready;
  wire wr = access & pwrite;
  wire rd = access & ~pwrite;
  wire [7:0] idx = word_index(paddr);
  wire standby = (mode_field == `IRQF_MODE_STANDBY);
  wire measuring = (mode_field == `IRQF_MODE_OPERATING_MODE_FIELD);
  wire soft_rst = wr & (idx == `IRQF_IDX_SRST) &
    (pwdata[7:0] == `IRQF_SRST_KEY);
  wire [`IRQF_NSRC-1:0] src_rise = event_src & ~src_prev;
  wire clr_status = rd & (idx == `IRQF_IDX_EVST);

  // ************************************************************
  // read decode
  // ************************************************************
  always @* begin
    rdata_mux = 32'h0000_0000;
    hit = 1'b1;
    case (idx)
      `IRQF_IDX_MASK2: rdata_mux[7:0] = irq_pin2_event_mask;
      `IRQF_IDX_FILT: rdata_mux[7:0] = {range_field, fast_bit,
        1'b0, ext_trig, rate_field};
      `IRQF_IDX_PWR: rdata_mux[1:0] = mode_field;
      `IRQF_IDX_SRST: rdata_mux = 32'h0000_0000;
      `IRQF_IDX_EVST: rdata_mux[`IRQF_NSRC-1:0] = ev_status;
      `IRQF_IDX_EVMSK: rdata_mux[`IRQF_NSRC-1:0] = ev_mask;
      default: hit = 1'b0;
    endcase
  end

  // ************************************************************
  // apb handshake, one wait state
  // ************************************************************
  always @(posedge mclk) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
      prdata <= (psel & penable & ~pready & ~pwrite) ? rdata_mux :
        32'h0000_0000;
      pslverr <= psel & penable & ~pready & ~hit;
    end
  end

  // ************************************************************
  // configuration registers
  // ************************************************************
  always @(posedge mclk) begin
    if (rst | soft_rst) begin
      irq_pin2_event_mask <= `IRQF_RST_MASK2;
      range_field <= FILT_RST[`IRQF_RANGE_HI:`IRQF_RANGE_LO];
      fast_bit <= FILT_RST[`IRQF_FAST_BIT];
      ext_trig <= FILT_RST[`IRQF_EXT_BIT];
      rate_field <= FILT_RST[`IRQF_RATE_HI:`IRQF_RATE_LO];
      mode_field <= `IRQF_RST_PWR;
      ev_mask <= `IRQF_RST_EVMSK;
    end else if (wr) begin
      case (idx)
        `IRQF_IDX_MASK2: irq_pin2_event_mask <= pwdata[7:0];
        `IRQF_IDX_FILT: begin
          range_field <= pwdata[`IRQF_RANGE_HI:`IRQF_RANGE_LO];
          // write of one cannot set; bus master code has no path here
          if (standby) begin
            fast_bit <= fast_bit & pwdata[`IRQF_FAST_BIT];
          end
          ext_trig <= pwdata[`IRQF_EXT_BIT];
          rate_field <= pwdata[`IRQF_RATE_HI:`IRQF_RATE_LO];
        end
        `IRQF_IDX_PWR: mode_field <= pwdata[1:0];
        `IRQF_IDX_EVMSK: ev_mask <= pwdata[`IRQF_NSRC-1:0];
        default: mode_field <= mode_field;
      endcase
    end
  end

  // ************************************************************
  // sticky event status, set wins over read clear
  // ************************************************************
  genvar g;
  generate
    for (g = 0; g < `IRQF_NSRC; g = g + 1) begin : g_ev
      always @(posedge mclk) begin
        if (rst) begin
          ev_status[g] <= 1'b0;
        end else if (src_rise[g]) begin
          ev_status[g] <= 1'b1;
        end else if (clr_status) begin
          ev_status[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // ************************************************************
  // source history for edge detection
  // ************************************************************
  always @(posedge mclk) begin
    if (rst) begin
      src_prev <= {`IRQF_NSRC{1'b0}};
    end else begin
      src_prev <= event_src;
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      trig_prev <= 1'b0;
    end else begin
      trig_prev <= second_irq_pin_in;
    end
  end

  // ************************************************************
  // per-source gating onto the second pin
  // ************************************************************
  wire [`IRQF_NSRC-1:0] routed_src;

  genvar s;
  generate
    for (s = 0; s < `IRQF_NSRC; s = s + 1) begin : g_route
      // one mask bit per source
      assign routed_src[s] = event_src[s] &
        irq_pin2_event_mask[s];
    end
  endgenerate

  // ************************************************************
  // second pin level and direction
  // ************************************************************
  wire pin2_any = |routed_src;

  // polarity flip after the level or
  wire next_pin2_out = pin2_any ^
    irq_pin2_event_mask[`IRQF_POL_BIT];

  // pin released while the far side drives triggers
  wire next_pin2_oe = ~ext_trig;

  always @(posedge mclk) begin
    if (rst) begin
      second_irq_pin_out <= 1'b0;
    end else begin
      second_irq_pin_out <= next_pin2_out;
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      second_irq_pin_oe <= 1'b0;
    end else begin
      second_irq_pin_oe <= next_pin2_oe;
    end
  end

  // ************************************************************
  // sample timing
  // ************************************************************
  reg [31:0] next_tick_cnt;
  reg next_sample_strobe;

  // last count of the current sample period
  wire [31:0] tick_last = rate_period(rate_field) - 32'h1;

  // rising edge seen on the pin in trigger mode
  wire trig_rise = second_irq_pin_in & ~trig_prev;

  always @* begin
    next_tick_cnt = 32'h0000_0000;
    next_sample_strobe = 1'b0;
    if (!measuring) begin
      // any mode other than measuring: timer cleared to zero, no samples
      next_tick_cnt = 32'h0000_0000;
      next_sample_strobe = 1'b0;
    end else if (ext_trig) begin
      // far side sets the sample times
      next_tick_cnt = 32'h0000_0000;
      next_sample_strobe = trig_rise;
    end else if (tick_cnt >= tick_last) begin
      // period complete, one strobe
      next_tick_cnt = 32'h0000_0000;
      next_sample_strobe = 1'b1;
    end else begin
      next_tick_cnt = tick_cnt + 32'h1;
      next_sample_strobe = 1'b0;
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      tick_cnt <= 32'h0000_0000;
    end else begin
      tick_cnt <= next_tick_cnt;
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      sample_strobe <= 1'b0;
    end else begin
      sample_strobe <= next_sample_strobe;
    end
  end

  // ************************************************************
  // interrupt level
  // ************************************************************
  wire next_irq = |(ev_status & ev_mask);

  always @(posedge mclk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq;
    end
  end

  // ************************************************************
  // configuration copies
  // ************************************************************
  always @(posedge mclk) begin
    if (rst) begin
      full_scale_range <= 2'h0;
    end else begin
      full_scale_range <= range_field;
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      fast_bus_mode_enable <= 1'b1;
    end else begin
      fast_bus_mode_enable <= fast_bit;
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      output_sample_rate <= 3'h0;
    end else begin
      output_sample_rate <= rate_field;
    end
  end

  // bandwidth code equals rate code: half the rate
  always @(posedge mclk) begin
    if (rst) begin
      filter_bw_code <= 3'h0;
    end else begin
      filter_bw_code <= rate_field;
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      operating_mode_field <= 2'h0;
    end else begin
      operating_mode_field <= mode_field;
    end
  end

endmodule

`default_nettype wire

// file: test/irqf_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// port checker
// ************************************************************
module irqf_monitor (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // apb
  input wire logic [9:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // config
  input wire logic fast_bus_mode_enable,
  input wire logic [2:0] output_sample_rate,
  input wire logic [2:0] filter_bw_code,
  input wire logic sample_strobe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  wire acc = psel && penable && pready && pwrite;
  wire srst_acc = acc && paddr == 10'h0c0 && pwdata[7:0] == 8'h52;
  wire clr_acc = acc && paddr == 10'h0b0 && !pwdata[5];
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence answer_s;
    !pready ##1 (pready && psel && penable);
  endsequence
  AST_WAIT: assert property (setup_s |=> answer_s)
    else $error("apb answer not after one wait");
  AST_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_INACC: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  AST_ERR: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_IDLE: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero while idle");
  AST_BW: assert property (filter_bw_code == output_sample_rate)
    else $error("bandwidth code differs from rate");
  AST_FAST_SET: assert property ($rose(fast_bus_mode_enable) |->
    $past(rst) || $past(rst, 2) || $past(rst, 3) || $past(srst_acc, 2))
    else $error("fast bus bit set without reset");
  AST_FAST_CLR: assert property ($fell(fast_bus_mode_enable) |->
    $past(clr_acc, 2))
    else $error("fast bus bit cleared without write");
  AST_STROBE: assert property (sample_strobe |=> !sample_strobe)
    else $error("strobe longer than one cycle");
endmodule
bind irqf_pin2_cfg irqf_monitor u_mon (.mclk, .rst, .paddr, .psel,
  .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
  .fast_bus_mode_enable, .output_sample_rate, .filter_bw_code,
  .sample_strobe);
`default_nettype wire

// file: test/irqf_host.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// host model: apb master and trigger source
// ************************************************************
module irqf_host (
  // clock
  input wire logic mclk,
  // apb master
  output logic [9:0] paddr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] pwdata,
  input wire logic pready,
  // trigger drive
  output logic trig
);
  initial begin
    {paddr, psel, penable, pwrite, pwdata, trig} = '0;
  end
  task automatic xfer(input logic w, input logic [9:0] a,
    input logic [7:0] d, output logic ok);
    int n;
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h0, d};
    psel <= 1'b1;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    ok = (n < 50);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic pulse();
    trig <= 1'b1;
    repeat (2) @(posedge mclk);
    trig <= 1'b0;
  endtask
endmodule
`default_nettype wire

// file: test/irq_pin2_map_and_filter_cfg_tb.sv
`timescale 1ns/1ps
`default_nettype none
module irq_pin2_map_and_filter_cfg_tb;
  logic mclk, rst, psel, penable, pwrite, pready, pslverr, fast, trig;
  logic pout, poe, strb, irq, pin;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [6:0] ev;
  logic [2:0] rate, bw;
  logic [1:0] rng, mode;
  logic [32:0] e;
  logic [32:0] exp_q[$];
  logic [7:0] m;
  int fail_count, total_checks, i, n;
  assign pin = poe ? pout : trig;
  irqf_host host (.mclk(mclk), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .pready(pready), .trig(trig));
  irqf_pin2_cfg #(.SLOW_PERIOD(64)) dut (.mclk(mclk), .rst(rst),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .event_src(ev), .second_irq_pin_in(pin),
    .second_irq_pin_out(pout), .second_irq_pin_oe(poe),
    .full_scale_range(rng), .fast_bus_mode_enable(fast),
    .output_sample_rate(rate), .filter_bw_code(bw),
    .operating_mode_field(mode), .sample_strobe(strb), .irq(irq));
  // ************************************************************
  // helpers
  // ************************************************************
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] x,
    input logic [31:0] g);
    total_checks++;
    if (g !== x) begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", nm, x, g);
    end
  endtask
  task automatic bus(input logic w, input logic [9:0] a,
    input logic [7:0] d, input logic [8:0] x);
    logic ok;
    exp_q.push_back({x[8], 24'h0, x[7:0]});
    host.xfer(w, a, d, ok);
    if (!ok) begin
      fail_count++;
      complete_run();
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 9'h0);
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] x);
    bus(1'b0, a, 8'h0, {1'b0, x});
  endtask
  task automatic wstb();
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (strb !== 1'b1 && n < 200);
    if (n >= 200) begin
      fail_count++;
      complete_run();
    end
  endtask
  always @(posedge mclk) begin
    if (psel && penable && pready === 1'b1) begin
      e = exp_q.pop_front();
      chk("pslverr", e[32], pslverr);
      if (!pwrite) chk("prdata", e[31:0], prdata);
    end
  end
  initial begin
    mclk = 0;
    forever #25 mclk = ~mclk;
  end
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    rst = 1;
    ev = 0;
    n = $urandom(52633);
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rd(10'h0ac, 8'h00);
    rd(10'h0b0, 8'h23);
    bus(1'b0, 10'h3fc, 8'h0, 9'h100);
    wr(10'h0c8, 8'h01);
    ev <= 7'h03;
    repeat (4) @(posedge mclk);
    chk("irq", 1, irq);
    rd(10'h0c4, 8'h03);
    @(posedge mclk);
    chk("irq", 0, irq);
    for (i = 0; i < 16; i++) begin
      m = (8'h1 << (i % 8)) | ((i > 7) ? 8'h80 : 8'h0);
      wr(10'h0ac, m);
      ev <= (7'($urandom) & ~m[6:0]) | ((i[0] ^ i[3]) ? m[6:0] : 7'h0);
      repeat (3) @(posedge mclk);
      chk("pin2", (|(ev & m[6:0])) ^ m[7], pout);
      chk("pin2_oe", 1, poe);
    end
    wr(10'h0b4, 8'h02);
    wr(10'h0b0, 8'h03);
    rd(10'h0b0, 8'h23);
    chk("mode", 2'h2, mode);
    for (i = 0; i < 7; i++) begin
      wr(10'h0b0, 8'(i));
      wstb();
      wstb();
      chk("period", 64 >> ((i > 5) ? 5 : i), n);
    end
    wr(10'h0b0, 8'h08);
    @(posedge mclk);
    chk("pin2_oe", 0, poe);
    fork
      host.pulse();
      wstb();
    join
    chk("trigger", 1, n <= 4);
    wr(10'h0b4, 8'h00);
    for (i = 0; i < 16; i++) begin
      m = $urandom;
      wr(10'h0b0, m | 8'h20);
      rd(10'h0b0, (m | 8'h20) & 8'hef);
      chk("range", m[7:6], rng);
      chk("rate", m[2:0], rate);
      chk("bw", m[2:0], bw);
    end
    wr(10'h0b0, 8'h03);
    wr(10'h0b0, 8'h23);
    rd(10'h0b0, 8'h03);
    chk("fast", 0, fast);
    wr(10'h0c0, 8'h52);
    rd(10'h0b0, 8'h23);
    chk("fast", 1, fast);
    complete_run();
  end
endmodule
`default_nettype wire
